//--- hdl/fses_cfg.svh
`ifndef FSES_CFG_SVH
`define FSES_CFG_SVH
// -----------------------------------------------------------------
// Opcodes
// -----------------------------------------------------------------
`define FSES_OPC_WRITE_ENABLE 8'h06
`define FSES_OPC_STATUS1_READ 8'h05
`define FSES_OPC_STATUS2_READ 8'h07
`define FSES_OPC_PROG_SUSPEND 8'h85
`define FSES_OPC_PROG_RESUME 8'h8a
`define FSES_OPC_PARAM_ERASE 8'h20
`define FSES_OPC_PARAM_ERASE_WIDE 8'h21
`define FSES_OPC_SECTOR_ERASE 8'hd8
`define FSES_OPC_SECTOR_ERASE_WIDE 8'hdc
`define FSES_OPC_ARRAY_ERASE_A 8'h60
`define FSES_OPC_ARRAY_ERASE_B 8'hc7
// -----------------------------------------------------------------
// Frame lengths and status bit positions
// -----------------------------------------------------------------
`define FSES_OPC_BITS 6'd8
`define FSES_ADDR3_BITS 6'd24
`define FSES_ADDR4_BITS 6'd32
`define FSES_SR1_WIP_BIT 0
`define FSES_SR1_WEL_BIT 1
`define FSES_SR1_EERR_BIT 5
`define FSES_SR2_PSUSP_BIT 0
// -----------------------------------------------------------------
// Sector geometry, as address bit positions
// -----------------------------------------------------------------
`define FSES_PARAM_SECT_BITS 13
`define FSES_SECT128_BITS 17
`define FSES_SECT512_BITS 19
`define FSES_PARAM_REGION_BITS 18
// -----------------------------------------------------------------
// Timing, in ns, and the clock period
// -----------------------------------------------------------------
`define FSES_CLK_NS 4
`define FSES_PSL_NS 40000
`define FSES_PROG_NS 400000
`define FSES_P4E_NS 200000
`define FSES_SE_NS 500000
`define FSES_BE_NS 2000000
`endif

//--- hdl/fses_pkg.sv
package fses_pkg;
  typedef enum logic [5:0] {
    FSES_IDLE = 6'h01,
    FSES_PROG = 6'h02,
    FSES_SWAIT = 6'h04,
    FSES_PSUSP = 6'h08,
    FSES_CHECK = 6'h10,
    FSES_ERASE = 6'h20
  } fses_op_t;
  typedef struct packed {
    logic psusp;
    logic eerr;
    logic write_enable_latch;
    logic write_in_progress;
  } fses_stat_t;
  typedef struct packed {
    logic ext_addr;
    logic uniform_256k;
    logic sector_512k;
    logic [2:0] bp;
  } fses_cfg_t;
endpackage

//--- hdl/fses_sync.sv
`timescale 1ns/1ns
module fses_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A level is taken only once two later stages agree, which rejects
  // a single sample caught mid-transition.
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          dout[i] <= RST_VAL[i];
        else if (s2_reg[i] == s3_reg[i])
          dout[i] <= s2_reg[i];
      end
    end
  endgenerate
endmodule

//--- hdl/fses_timer.sv
`timescale 1ns/1ns
module fses_timer #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic done
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= load_val;
    else if (run && cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  assign done = run && !load && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
endmodule

//--- hdl/fses_top.sv
`timescale 1ns/1ns
`include "fses_cfg.svh"
module fses_top #(
  parameter int ARRAY_AW = 26,
  parameter int PSL_CYC = `FSES_PSL_NS / `FSES_CLK_NS,
  parameter int PROG_CYC = `FSES_PROG_NS / `FSES_CLK_NS,
  parameter int P4E_CYC = `FSES_P4E_NS / `FSES_CLK_NS,
  parameter int SE_CYC = `FSES_SE_NS / `FSES_CLK_NS,
  parameter int BE_CYC = `FSES_BE_NS / `FSES_CLK_NS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic io0_pin,
  input wire logic io4_pin,
  input fses_pkg::fses_cfg_t cfg,
  input wire logic asp_range_protected,
  input wire logic program_start,
  input wire logic clear_status,
  output fses_pkg::fses_stat_t status,
  output logic [31:0] erase_addr,
  output logic erase_is_param,
  output logic erase_range_512k,
  output logic io1_out,
  output logic io1_oe
);
  import fses_pkg::*;

  // -----------------------------------------------------------------
  // Pin sampling
  // -----------------------------------------------------------------
  logic sck_f;
  logic cs_n_f;
  logic io0_f;
  logic io4_f;
  logic sck_q_reg;
  logic cs_q_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  fses_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({sck_pin, cs_n_pin, io0_pin, io4_pin}),
    .dout({sck_f, cs_n_f, io0_f, io4_f})
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sck_q_reg <= 1'b0;
      cs_q_reg <= 1'b1;
    end
    else
    begin
      sck_q_reg <= sck_f;
      cs_q_reg <= cs_n_f;
    end
  end

  assign sck_rise = sck_f && !sck_q_reg;
  assign sck_fall = !sck_f && sck_q_reg;
  assign cs_rise = cs_n_f && !cs_q_reg;
  assign cs_fall = !cs_n_f && cs_q_reg;

  // -----------------------------------------------------------------
  // Frame shifter
  // -----------------------------------------------------------------
  logic [5:0] bit_cnt_reg;
  logic [7:0] opc_reg;
  logic [31:0] addr_reg;
  logic bad_reg;
  logic [7:0] opc_next;

  assign opc_next = {opc_reg[6:0], io0_f};

  // Both lanes carry the same command; a lane mismatch spoils the frame.
  always_ff @(posedge clk_sys)
  begin
    if (rst || cs_fall)
    begin
      bit_cnt_reg <= 6'h00;
      opc_reg <= 8'h00;
      addr_reg <= 32'h0;
      bad_reg <= 1'b0;
    end
    else if (sck_rise && !cs_n_f)
    begin
      if (bit_cnt_reg != 6'h3f)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg < `FSES_OPC_BITS)
        opc_reg <= opc_next;
      else
        addr_reg <= {addr_reg[30:0], io0_f};
      if (io0_f != io4_f)
        bad_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Command decode at select rise
  // -----------------------------------------------------------------
  logic is_param;
  logic is_sect;
  logic is_arr;
  logic [5:0] alen;
  logic addr_done;
  logic ok8;

  assign is_param = opc_reg == `FSES_OPC_PARAM_ERASE || opc_reg == `FSES_OPC_PARAM_ERASE_WIDE;
  assign is_sect = opc_reg == `FSES_OPC_SECTOR_ERASE || opc_reg == `FSES_OPC_SECTOR_ERASE_WIDE;
  assign is_arr = opc_reg == `FSES_OPC_ARRAY_ERASE_A || opc_reg == `FSES_OPC_ARRAY_ERASE_B;
  assign alen = (cfg.ext_addr || opc_reg == `FSES_OPC_PARAM_ERASE_WIDE
                 || opc_reg == `FSES_OPC_SECTOR_ERASE_WIDE)
                ? `FSES_ADDR4_BITS : `FSES_ADDR3_BITS;
  assign addr_done = !bad_reg && bit_cnt_reg == `FSES_OPC_BITS + alen;
  assign ok8 = !bad_reg && bit_cnt_reg == `FSES_OPC_BITS;

  // -----------------------------------------------------------------
  // Operation sequencer
  // -----------------------------------------------------------------
  fses_op_t op_reg;
  fses_op_t op_next;
  logic tmr_load;
  logic [31:0] tmr_val;
  logic tmr_done;
  logic lat_load;
  logic lat_done;
  logic take;
  logic wel_set;
  logic wel_clr;
  logic err_set;
  logic bp_hit;
  logic in_param;
  logic [6:0] bp_lim;
  logic [31:0] addr_mask;

  // Block protection covers a top fraction of the array in 64ths.
  assign bp_lim = 7'h40 - (7'h01 << (cfg.bp - 3'h1));
  assign bp_hit = cfg.bp != 3'h0
                  && {1'b0, erase_addr[ARRAY_AW-1 -: 6]} >= bp_lim;
  assign in_param = erase_addr[ARRAY_AW-1:`FSES_PARAM_REGION_BITS] == '0;
  assign wel_set = cs_rise && opc_reg == `FSES_OPC_WRITE_ENABLE && ok8
                   && op_reg == FSES_IDLE;

  always_comb
  begin
    op_next = op_reg;
    tmr_load = 1'b0;
    tmr_val = 32'h0;
    lat_load = 1'b0;
    take = 1'b0;
    wel_clr = 1'b0;
    err_set = 1'b0;
    case (op_reg)
      FSES_IDLE:
      begin
        if (cs_rise && is_arr)
        begin
          if (ok8 && status.write_enable_latch && cfg.bp == 3'h0)
          begin
            op_next = FSES_ERASE;
            tmr_load = 1'b1;
            tmr_val = 32'(BE_CYC);
          end
          else
            wel_clr = 1'b1;
        end
        else if (cs_rise && is_param && cfg.uniform_256k)
          op_next = FSES_IDLE;
        else if (cs_rise && (is_param || is_sect))
        begin
          if (addr_done && status.write_enable_latch)
          begin
            op_next = FSES_CHECK;
            take = 1'b1;
          end
          else
            wel_clr = 1'b1;
        end
        else if (program_start)
        begin
          op_next = FSES_PROG;
          tmr_load = 1'b1;
          tmr_val = 32'(PROG_CYC);
        end
      end
      FSES_PROG:
      begin
        if (tmr_done)
          op_next = FSES_IDLE;
        else if (cs_rise && opc_reg == `FSES_OPC_PROG_SUSPEND && ok8)
        begin
          op_next = FSES_SWAIT;
          lat_load = 1'b1;
        end
      end
      FSES_SWAIT:
      begin
        // Programming keeps running until the latency ends; it may finish.
        if (tmr_done)
          op_next = FSES_IDLE;
        else if (lat_done)
          op_next = FSES_PSUSP;
      end
      FSES_PSUSP:
      begin
        if (cs_rise && opc_reg == `FSES_OPC_PROG_RESUME && ok8)
          op_next = FSES_PROG;
      end
      FSES_CHECK:
      begin
        op_next = FSES_IDLE;
        if (erase_is_param && !in_param)
          wel_clr = 1'b1;
        else if (bp_hit || asp_range_protected)
        begin
          err_set = 1'b1;
          wel_clr = 1'b1;
        end
        else
        begin
          op_next = FSES_ERASE;
          tmr_load = 1'b1;
          tmr_val = erase_is_param ? 32'(P4E_CYC) : 32'(SE_CYC);
        end
      end
      FSES_ERASE:
      begin
        if (tmr_done)
        begin
          op_next = FSES_IDLE;
          wel_clr = 1'b1;
        end
      end
      default:
        op_next = FSES_IDLE;
    endcase
  end

  // Work left over is frozen while suspended, but the timer also runs
  // through the suspend latency, so each resume and suspend advances the program.
  fses_timer #(.W(32)) u_op_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .run(op_reg == FSES_PROG || op_reg == FSES_SWAIT || op_reg == FSES_ERASE),
    .done(tmr_done)
  );

  fses_timer #(.W(32)) u_lat_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(lat_load),
    .load_val(32'(PSL_CYC)),
    .run(op_reg == FSES_SWAIT),
    .done(lat_done)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      op_reg <= FSES_IDLE;
    else
      op_reg <= op_next;
  end

  // -----------------------------------------------------------------
  // Erase target
  // -----------------------------------------------------------------
  always_comb
  begin
    addr_mask = 32'hffff_ffff;
    if (is_param)
      addr_mask = addr_mask << `FSES_PARAM_SECT_BITS;
    else if (cfg.sector_512k)
      addr_mask = addr_mask << `FSES_SECT512_BITS;
    else
      addr_mask = addr_mask << `FSES_SECT128_BITS;
    addr_mask[31:ARRAY_AW] = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      erase_addr <= 32'h0;
      erase_is_param <= 1'b0;
      erase_range_512k <= 1'b0;
    end
    else if (take)
    begin
      erase_addr <= addr_reg & addr_mask;
      erase_is_param <= is_param;
      erase_range_512k <= is_sect && cfg.sector_512k;
    end
  end

  // -----------------------------------------------------------------
  // Status flags
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      status <= '0;
    else
    begin
      status.write_in_progress <= op_next == FSES_PROG || op_next == FSES_SWAIT
                    || op_next == FSES_ERASE;
      status.psusp <= op_next == FSES_PSUSP;
      if (wel_set)
        status.write_enable_latch <= 1'b1;
      else if (wel_clr)
        status.write_enable_latch <= 1'b0;
      if (err_set)
        status.eerr <= 1'b1;
      else if (clear_status)
        status.eerr <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Status readout
  // -----------------------------------------------------------------
  logic [7:0] out_sh_reg;
  logic [7:0] sr1;
  logic [7:0] sr2;

  always_comb
  begin
    sr1 = 8'h00;
    sr2 = 8'h00;
    sr1[`FSES_SR1_WIP_BIT] = status.write_in_progress;
    sr1[`FSES_SR1_WEL_BIT] = status.write_enable_latch;
    sr1[`FSES_SR1_EERR_BIT] = status.eerr;
    sr2[`FSES_SR2_PSUSP_BIT] = status.psusp;
  end

  // Status reads are served in every state, suspended ones included.
  // The byte is captured once, so a long read repeats a snapshot.
  always_ff @(posedge clk_sys)
  begin
    if (rst || cs_rise)
    begin
      out_sh_reg <= 8'h00;
      io1_oe <= 1'b0;
    end
    else if (sck_rise && !cs_n_f && bit_cnt_reg == 6'h07)
    begin
      if (opc_next == `FSES_OPC_STATUS1_READ)
      begin
        out_sh_reg <= sr1;
        io1_oe <= 1'b1;
      end
      else if (opc_next == `FSES_OPC_STATUS2_READ)
      begin
        out_sh_reg <= sr2;
        io1_oe <= 1'b1;
      end
    end
    else if (sck_fall && io1_oe && bit_cnt_reg > `FSES_OPC_BITS)
      out_sh_reg <= {out_sh_reg[6:0], out_sh_reg[7]};
  end

  assign io1_out = out_sh_reg[7];

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  logic [31:0] swait_cnt;

  always_ff @(posedge clk_sys)
  begin
    if (rst || op_reg != FSES_SWAIT)
      swait_cnt <= 32'h0;
    else
      swait_cnt <= swait_cnt + 32'h1;
  end

  sequence s_resume_taken;
    cs_rise && opc_reg == `FSES_OPC_PROG_RESUME && ok8 && op_reg == FSES_PSUSP;
  endsequence

  property p_suspend_needs_prog;
    @(posedge clk_sys) disable iff (rst)
      cs_rise && opc_reg == `FSES_OPC_PROG_SUSPEND && op_reg != FSES_PROG
      && op_reg != FSES_SWAIT
      |=> op_reg != FSES_SWAIT;
  endproperty
  a_suspend_needs_prog: assert property (p_suspend_needs_prog)
    else $error("suspend taken without programming");

  property p_suspended_holds;
    @(posedge clk_sys) disable iff (rst)
      op_reg == FSES_PSUSP && !(cs_rise && opc_reg == `FSES_OPC_PROG_RESUME)
      |=> op_reg == FSES_PSUSP;
  endproperty
  a_suspended_holds: assert property (p_suspended_holds)
    else $error("suspend left by a command other than resume");

  property p_psusp_flag;
    @(posedge clk_sys) disable iff (rst)
      $rose(op_reg == FSES_PSUSP) |-> status.psusp && !status.write_in_progress;
  endproperty
  a_psusp_flag: assert property (p_psusp_flag)
    else $error("suspended flag or busy wrong on suspend");

  property p_latency;
    @(posedge clk_sys) disable iff (rst)
      swait_cnt <= 32'(PSL_CYC);
  endproperty
  a_latency: assert property (p_latency)
    else $error("suspend latency exceeded");

  property p_resume_ignored;
    @(posedge clk_sys) disable iff (rst)
      cs_rise && opc_reg == `FSES_OPC_PROG_RESUME && op_reg == FSES_IDLE
      && !program_start |=> op_reg == FSES_IDLE && !status.write_in_progress;
  endproperty
  a_resume_ignored: assert property (p_resume_ignored)
    else $error("resume acted with nothing suspended");

  property p_resume_runs;
    @(posedge clk_sys) disable iff (rst)
      s_resume_taken |=> op_reg == FSES_PROG && status.write_in_progress ##1 !status.psusp;
  endproperty
  a_resume_runs: assert property (p_resume_runs)
    else $error("resume did not restart programming");

  property p_erase_needs_wel;
    @(posedge clk_sys) disable iff (rst)
      $rose(op_reg == FSES_ERASE) |-> $past(status.write_enable_latch);
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel)
    else $error("erase started without write enable");

  property p_short_frame;
    @(posedge clk_sys) disable iff (rst)
      cs_rise && (is_param || is_sect) && !addr_done |=> op_reg != FSES_CHECK;
  endproperty
  a_short_frame: assert property (p_short_frame)
    else $error("erase taken on wrong address length");

  property p_erase_busy;
    @(posedge clk_sys) disable iff (rst)
      op_reg == FSES_ERASE |-> status.write_in_progress;
  endproperty
  a_erase_busy: assert property (p_erase_busy)
    else $error("busy low during erase");

  property p_protect_err;
    @(posedge clk_sys) disable iff (rst)
      op_reg == FSES_CHECK && !erase_is_param && (bp_hit || asp_range_protected)
      |=> status.eerr && op_reg == FSES_IDLE;
  endproperty
  a_protect_err: assert property (p_protect_err)
    else $error("protected erase did not flag error");

  property p_big_param;
    @(posedge clk_sys) disable iff (rst)
      op_reg == FSES_CHECK && erase_is_param && !in_param && !clear_status
      |=> $stable(status.eerr) && op_reg == FSES_IDLE;
  endproperty
  a_big_param: assert property (p_big_param)
    else $error("parameter erase outside region misbehaved");

  property p_array_bp;
    @(posedge clk_sys) disable iff (rst)
      cs_rise && is_arr && cfg.bp != 3'h0 && op_reg == FSES_IDLE
      |=> op_reg != FSES_ERASE && !$rose(status.eerr);
  endproperty
  a_array_bp: assert property (p_array_bp)
    else $error("array erase with block protect set");

  property p_wel_after_erase;
    @(posedge clk_sys) disable iff (rst)
      op_reg == FSES_ERASE && tmr_done |=> !status.write_enable_latch;
  endproperty
  a_wel_after_erase: assert property (p_wel_after_erase)
    else $error("write enable survived erase");
endmodule

//--- tb/fses_host_model.sv
`timescale 1ns/1ns
module fses_host_model (
  input wire logic clk_sys,
  input wire logic io1_out,
  input wire logic io1_oe,
  output logic sck_pin,
  output logic cs_n_pin,
  output logic io0_pin,
  output logic io4_pin
);
  initial
  begin
    sck_pin = 1'b0;
    cs_n_pin = 1'b1;
    io0_pin = 1'b0;
    io4_pin = 1'b1;
  end

  // One serial bit on both lanes, 64 ns per bit; the far side's data is sampled at the rise.
  task automatic bt(input logic v, output logic s);
    io0_pin = v;
    io4_pin = v;
    repeat (8) @(negedge clk_sys);
    sck_pin = 1'b1;
    s = io1_out;
    repeat (8) @(negedge clk_sys);
    sck_pin = 1'b0;
  endtask

  // The lanes show the inverse of the last bit after deselect, so stale data never looks valid.
  task automatic fin();
    cs_n_pin = 1'b1;
    io0_pin = ~io0_pin;
    io4_pin = ~io4_pin;
    repeat (12) @(negedge clk_sys);
  endtask

  task automatic send(input logic [39:0] w, input int nb);
    logic s;
    @(negedge clk_sys);
    cs_n_pin = 1'b0;
    for (int i = 39; i > 39 - nb; i--)
      bt(w[i], s);
    fin();
  endtask

  task automatic rd(input logic [7:0] opc, output logic [7:0] b, output logic oe);
    logic s;
    @(negedge clk_sys);
    cs_n_pin = 1'b0;
    for (int i = 7; i >= 0; i--)
      bt(opc[i], s);
    for (int i = 7; i >= 0; i--)
      bt(1'b0, b[i]);
    oe = io1_oe;
    fin();
  endtask
endmodule

//--- tb/fses_top_bench.sv
`timescale 1ns/1ns
module fses_top_bench;
  import fses_pkg::*;
  localparam int PSL = 20;
  localparam int PRG = 2000;
  localparam int ERS = 30;
  localparam int BLK = 50;
  logic clk_sys;
  logic rst;
  logic sck_pin;
  logic cs_n_pin;
  logic io0_pin;
  logic io4_pin;
  fses_cfg_t cfg;
  logic asp_range_protected;
  logic program_start;
  logic clear_status;
  fses_stat_t status;
  logic [31:0] erase_addr;
  logic erase_is_param;
  logic erase_range_512k;
  logic io1_out;
  logic io1_oe;
  logic [7:0] b;
  logic oe;
  int num_errors = 0;
  int n_checks = 0;

  fses_top #(.PSL_CYC(PSL), .PROG_CYC(PRG), .P4E_CYC(ERS), .SE_CYC(ERS), .BE_CYC(BLK)) u_fses_top (
    .clk_sys(clk_sys), .rst(rst), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin),
    .io0_pin(io0_pin), .io4_pin(io4_pin), .cfg(cfg),
    .asp_range_protected(asp_range_protected), .program_start(program_start),
    .clear_status(clear_status), .status(status), .erase_addr(erase_addr),
    .erase_is_param(erase_is_param), .erase_range_512k(erase_range_512k),
    .io1_out(io1_out), .io1_oe(io1_oe));

  fses_host_model u_fses_host_model (
    .clk_sys(clk_sys), .io1_out(io1_out), .io1_oe(io1_oe), .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin), .io0_pin(io0_pin), .io4_pin(io4_pin));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Status nibble is {psusp, eerr, wel, wip}.
  task automatic st(input logic [3:0] e);
    chk({28'h0000000, status}, {28'h0000000, e});
  endtask

  task automatic wst(input logic [3:0] e, input int n);
    for (int i = 0; i < n && status !== e; i++)
      @(negedge clk_sys);
    st(e);
    if (status !== e)
      test_done();
  endtask

  task automatic snd(input logic [39:0] w, input int nb);
    u_fses_host_model.send(w, nb);
  endtask

  task automatic we();
    snd({8'h06, 32'h00000000}, 8);
    st(4'h2);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    asp_range_protected = 1'b0;
    program_start = 1'b0;
    clear_status = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    st(4'h0);
    snd({8'hd8, 32'h00000000}, 32);
    st(4'h0);
    we();
    snd({8'hd8, 24'h123456, 8'h00}, 32);
    st(4'h3);
    chk(erase_addr, 32'h00120000);
    chk({31'h00000000, erase_range_512k}, 32'h00000000);
    wst(4'h0, ERS + 10);
    we();
    snd({8'hd8, 32'h00020000}, 40);
    st(4'h0);
    we();
    asp_range_protected = 1'b1;
    snd({8'hd8, 32'h00000000}, 32);
    st(4'h4);
    asp_range_protected = 1'b0;
    clear_status = 1'b1;
    @(negedge clk_sys);
    clear_status = 1'b0;
    @(negedge clk_sys);
    st(4'h0);
    cfg.uniform_256k = 1'b1;
    we();
    snd({8'h20, 32'h00000000}, 32);
    st(4'h2);
    cfg.uniform_256k = 1'b0;
    snd({8'h21, 32'h00002345}, 40);
    st(4'h3);
    chk(erase_addr, 32'h00002000);
    chk({31'h00000000, erase_is_param}, 32'h00000001);
    wst(4'h0, ERS + 10);
    we();
    snd({8'h20, 24'h100000, 8'h00}, 32);
    chk({30'h00000000, status.eerr, status.write_in_progress}, 32'h00000000);
    cfg.ext_addr = 1'b1;
    cfg.sector_512k = 1'b1;
    we();
    snd({8'hd8, 32'h0107ffff}, 40);
    st(4'h3);
    chk(erase_addr, 32'h01000000);
    chk({31'h00000000, erase_range_512k}, 32'h00000001);
    wst(4'h0, ERS + 10);
    cfg.ext_addr = 1'b0;
    we();
    snd({8'hdc, 32'h00040000}, 40);
    st(4'h3);
    wst(4'h0, ERS + 10);
    cfg.bp = 3'h1;
    we();
    snd({8'hdc, 32'h03f00000}, 40);
    st(4'h4);
    clear_status = 1'b1;
    @(negedge clk_sys);
    clear_status = 1'b0;
    @(negedge clk_sys);
    st(4'h0);
    we();
    snd({8'h60, 32'h00000000}, 8);
    st(4'h0);
    cfg.bp = 3'h0;
    we();
    snd({8'hc7, 32'h00000000}, 16);
    st(4'h0);
    asp_range_protected = 1'b1;
    we();
    snd({8'h60, 32'h00000000}, 8);
    st(4'h3);
    wst(4'h0, BLK + 10);
    we();
    snd({8'hc7, 32'h00000000}, 8);
    st(4'h3);
    wst(4'h0, BLK + 10);
    asp_range_protected = 1'b0;
    snd({8'h85, 32'h00000000}, 8);
    st(4'h0);
    program_start = 1'b1;
    @(negedge clk_sys);
    program_start = 1'b0;
    @(negedge clk_sys);
    st(4'h1);
    u_fses_host_model.rd(8'h05, b, oe);
    chk({24'h000000, b}, 32'h00000001);
    snd({8'h85, 32'h00000000}, 8);
    wst(4'h8, PSL + 10);
    u_fses_host_model.rd(8'h07, b, oe);
    chk({23'h000000, oe, b}, 32'h00000101);
    snd({8'h06, 32'h00000000}, 8);
    st(4'h8);
    snd({8'h8a, 32'h00000000}, 8);
    st(4'h1);
    wst(4'h0, PRG + 10);
    snd({8'h8a, 32'h00000000}, 8);
    st(4'h0);
    test_done();
  end
endmodule
